// ---- ccd_color_gain_steering.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_color_gain_steering
  import steer_pkg::*;
#(
  parameter int HCNT_WIDTH = HCNT_W
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pix_en,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire logic field_indicator,
  input wire steer_pkg::steer_mode_t ctl_mode,
  input wire logic [7:0] operating_mode_reg,
  input wire logic internal_mode,
  input wire logic [1:0] cfg_sel,
  input wire logic pga_wr,
  input wire logic [PGA_W-1:0] pga_wdata,
  input wire logic vga_wr,
  input wire logic [VGA_W-1:0] vga_wdata,
  input wire logic clamp_wr,
  input wire logic [CLAMP_W-1:0] clamp_wdata,
  input wire logic [HCNT_WIDTH-1:0] clamp_on_pos,
  input wire logic [HCNT_WIDTH-1:0] clamp_off_pos,
  input wire logic [3:0] clamp_line_div,
  input wire logic ext_black_clamp_pulse,
  output logic [1:0] gain_sel,
  output logic [PGA_W-1:0] gain_value,
  output logic [VGA_W-1:0] vga_code,
  output logic [CLAMP_W-1:0] clamp_level,
  output logic clamp_loop_en,
  output logic clamp_active,
  output logic black_clamp_pulse,
  output logic [HCNT_WIDTH-1:0] h_count
);
  import steer_pkg::*;

  logic vs_q;
  logic hs_q;
  logic fld_q;
  logic [2:0] hdly_q;
  logic [PGA_W-1:0] pga_q [4];
  logic [VGA_W-1:0] vga_q;
  logic [CLAMP_W-1:0] clamp_q;
  logic [1:0] line_kind_q;
  logic [1:0] line_kind_d;
  logic vs_pend_q;
  logic [3:0] line_cnt_q;
  logic int_clamp_q;
  logic hcnt_reset;
  logic vs_fall;
  logic hs_fall;
  logic fld_fall;
  logic fld_rise;
  logic use_field;
  logic clamp_line;
  logic clamp_src;

  assign vs_fall = vs_q && !vertical_sync;
  assign hs_fall = hs_q && !horizontal_sync;
  assign use_field = (ctl_mode == MODE_MOSAIC_ILC);
  assign fld_fall = use_field && fld_q && !field_indicator;
  assign fld_rise = use_field && !fld_q && field_indicator;
  // The fall is seen on edge one, so the counter clears on edge six
  assign hcnt_reset = (hdly_q == HSYNC_DELAY - 3'h1);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vs_q <= 1'b1;
      hs_q <= 1'b1;
      fld_q <= 1'b0;
    end
    else
    begin
      vs_q <= vertical_sync;
      hs_q <= horizontal_sync;
      fld_q <= field_indicator;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      hdly_q <= 3'h0;
    else if (hs_fall)
      hdly_q <= 3'h1;
    else if (hdly_q != 3'h0 && !hcnt_reset)
      hdly_q <= hdly_q + 3'h1;
    else
      hdly_q <= 3'h0;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      h_count <= '0;
    else if (hcnt_reset)
      h_count <= '0;
    else if (pix_en)
      h_count <= h_count + 1'b1;
  end

  // Frame sync arms the first-line selection for the next line resync
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      vs_pend_q <= 1'b0;
    else if (vs_fall)
      vs_pend_q <= 1'b1;
    else if (hcnt_reset)
      vs_pend_q <= 1'b0;
  end

  always_comb
  begin
    line_kind_d = line_kind_q;
    case (ctl_mode)
      MODE_MOSAIC_ILC:
      begin
        if (fld_fall)
          line_kind_d = LINE_A;
        else if (fld_rise)
          line_kind_d = LINE_B;
        else
          line_kind_d = fld_q ? LINE_B : LINE_A;
      end
      MODE_THREE, MODE_FOUR:
        line_kind_d = LINE_A;
      MODE_MOSAIC_SEP, MODE_MOSAIC_REP, MODE_THREE_II, MODE_FOUR_II:
      begin
        if (hcnt_reset && (vs_pend_q || vs_fall))
          line_kind_d = LINE_A;
        else if (hcnt_reset)
          line_kind_d = (line_kind_q == LINE_A) ? LINE_B : LINE_A;
      end
      default:
        line_kind_d = LINE_A;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      line_kind_q <= LINE_A;
    else
      line_kind_q <= line_kind_d;
  end

  steer_seq u_seq (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pix_en(pix_en),
    .line_restart(hcnt_reset || vs_fall || fld_fall || fld_rise),
    .line_kind(line_kind_d),
    .mode(ctl_mode),
    .gain_sel(gain_sel)
  );

  // Four colour gain registers, one per channel
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pga
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          pga_q[g] <= '0;
        else if (pga_wr && cfg_sel == 2'(g))
          pga_q[g] <= pga_wdata;
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gain_value <= '0;
    else
      gain_value <= pga_q[gain_sel];
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vga_q <= '0;
      clamp_q <= '0;
    end
    else
    begin
      if (vga_wr)
        vga_q <= vga_wdata;
      if (clamp_wr)
        clamp_q <= clamp_wdata;
    end
  end
  assign vga_code = vga_q;
  // Level stays valid as a fixed offset even with the loop off
  assign clamp_level = clamp_q;
  assign clamp_loop_en = !operating_mode_reg[OPR_CLAMP_OFF_BIT];

  // Line divider lets the loop update every Nth line
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      line_cnt_q <= 4'h0;
    else if (vs_fall)
      line_cnt_q <= 4'h0;
    else if (hcnt_reset)
      line_cnt_q <= (line_cnt_q >= clamp_line_div) ? 4'h0 : line_cnt_q + 4'h1;
  end
  assign clamp_line = (line_cnt_q == 4'h0);

  // Internal mode builds the clamp pulse from counter positions
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      int_clamp_q <= 1'b0;
    else if (hcnt_reset)
      int_clamp_q <= 1'b0;
    else if (h_count == clamp_on_pos)
      int_clamp_q <= 1'b1;
    else if (h_count == clamp_off_pos)
      int_clamp_q <= 1'b0;
  end
  // External pulse placement is the timing source's job
  assign clamp_src = internal_mode ? int_clamp_q : ext_black_clamp_pulse;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      black_clamp_pulse <= 1'b0;
      clamp_active <= 1'b0;
    end
    else
    begin
      black_clamp_pulse <= clamp_src;
      clamp_active <= clamp_src && clamp_line && clamp_loop_en;
    end
  end
endmodule
`default_nettype wire

// ---- ccd_gain_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_gain_properties
  import steer_pkg::*;
#(
  parameter int HCNT_WIDTH = HCNT_W
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pix_en,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire logic field_indicator,
  input wire steer_pkg::steer_mode_t ctl_mode,
  input wire logic [7:0] operating_mode_reg,
  input wire logic vga_wr,
  input wire logic [VGA_W-1:0] vga_wdata,
  input wire logic clamp_wr,
  input wire logic [CLAMP_W-1:0] clamp_wdata,
  input wire logic [1:0] gain_sel,
  input wire logic [VGA_W-1:0] vga_code,
  input wire logic [CLAMP_W-1:0] clamp_level,
  input wire logic clamp_loop_en,
  input wire logic clamp_active,
  input wire logic [HCNT_WIDTH-1:0] h_count
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence hs_fall;
    $fell(horizontal_sync);
  endsequence
  a_hcnt_resync: assert property (hs_fall |-> ##6 h_count == '0)
    else $error("h_count not cleared");
  a_ilc_start: assert property ((hs_fall and ctl_mode == MODE_MOSAIC_ILC)
    |-> ##6 gain_sel == (field_indicator ? 2'h2 : 2'h0)) else $error("interlaced start");
  a_line_zero: assert property ((hs_fall and ctl_mode inside {MODE_THREE, MODE_FOUR})
    |-> ##6 gain_sel == 2'h0) else $error("line start not zero");
  // A pixel that meets a resync restarts the line instead of stepping
  a_four_step: assert property (pix_en && ctl_mode == MODE_FOUR && !$fell(vertical_sync)
    |=> h_count == '0 || gain_sel == $past(gain_sel) + 2'h1) else $error("four step");
  a_three_step: assert property (pix_en && ctl_mode == MODE_THREE && !$fell(vertical_sync)
    |=> h_count == '0 || gain_sel == ($past(gain_sel) == 2'h2 ? 2'h0 : $past(gain_sel) + 2'h1))
    else $error("three step");
  a_vga_write: assert property (vga_wr |=> vga_code == $past(vga_wdata))
    else $error("vga write");
  a_clamp_write: assert property (clamp_wr |=> clamp_level == $past(clamp_wdata))
    else $error("clamp write");
  a_loop_off: assert property (clamp_loop_en == !operating_mode_reg[OPR_CLAMP_OFF_BIT])
    else $error("loop enable");
  a_clamp_gate: assert property (clamp_active |-> !$past(operating_mode_reg[OPR_CLAMP_OFF_BIT]))
    else $error("clamp while off");
endmodule
bind ccd_color_gain_steering ccd_gain_properties #(.HCNT_WIDTH(HCNT_WIDTH)) chk (.*);
`default_nettype wire

// ---- steer_pkg.sv ----
// Overview of operation
// - Mosaic interlaced: field falling edge restarts at the 0-1 alternating line.
// - Mosaic interlaced: field rising edge restarts at the 2-3 alternating line.
// - Mosaic interlaced: each line sync fall resets selection to 0 (odd) or 2 (even).
// - Mosaic repeat: frame sync selects 0-1 line; line syncs alternate 0-1 and 1-2.
// - Mosaic repeat: same pattern every field, field indicator unused.
// - Three-colour: lines cycle 0,1,2; frame and line sync falls reset to 0.
// - Three-colour II: frame sync selects 0-1-2; line syncs alternate with 2-1-0.
// - Four-colour: lines cycle 0,1,2,3; frame and line sync falls reset to 0.
// - Four-colour II: frame sync selects 0-1-2-3; line syncs alternate with 2-3-0-1.
// - Every mode except mosaic interlaced ignores the field indicator.
// - Four independent 64-step colour gain settings, one per channel.
// - Variable gain amplifier setting held as a 10-bit code.
// - Black clamp target level held as an 8-bit value.
// - Clamp loop runs once per line in the black pulse, optionally less often.
// - Mode bit D2 disables the clamp loop; clamp level stays as fixed offset.
// - Internal mode makes the clamp pulse from counter positions; host supplies only syncs.
// - Mosaic separate: frame sync selects 0-1 line; line syncs alternate with 2-3.
// - Control mode field at address 0x06 selects one of seven steering modes.
// - Horizontal counter and steering resync on sixth clock edge after line sync fall.
package steer_pkg;
  localparam logic [7:0] CTL_MODE_ADDR = 8'h06;
  localparam int OPR_CLAMP_OFF_BIT = 2;
  localparam int MODE_W = 3;
  localparam int PGA_W = 6;
  localparam int VGA_W = 10;
  localparam int CLAMP_W = 8;
  localparam int HCNT_W = 12;
  localparam int SEL_W = 2;
  localparam logic [2:0] HSYNC_DELAY = 3'h6;
  typedef enum logic [2:0] {
    MODE_MOSAIC_SEP = 3'b000,
    MODE_MOSAIC_ILC = 3'b001,
    MODE_MOSAIC_REP = 3'b010,
    MODE_THREE = 3'b011,
    MODE_THREE_II = 3'b100,
    MODE_FOUR = 3'b101,
    MODE_FOUR_II = 3'b110
  } steer_mode_t;
  localparam logic [1:0] LINE_A = 2'h0;
  localparam logic [1:0] LINE_B = 2'h1;
  localparam logic [1:0] LINE_C = 2'h2;
endpackage

// ---- steer_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module steer_seq
  import steer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pix_en,
  input wire logic line_restart,
  input wire logic [1:0] line_kind,
  input wire steer_pkg::steer_mode_t mode,
  output logic [1:0] gain_sel
);
  logic [1:0] pos_q;
  logic [1:0] pos_d;
  logic [1:0] base;
  logic [1:0] wrap;
  logic rev;
  assign wrap = (mode == MODE_THREE || mode == MODE_THREE_II) ? 2'h2 :
                (mode == MODE_FOUR || mode == MODE_FOUR_II) ? 2'h3 : 2'h1;
  assign rev = (mode == MODE_THREE_II) && (line_kind == LINE_B);
  always_comb
  begin
    base = 2'h0;
    case (mode)
      MODE_MOSAIC_SEP, MODE_MOSAIC_ILC: base = (line_kind == LINE_B) ? 2'h2 : 2'h0;
      MODE_MOSAIC_REP: base = (line_kind == LINE_B) ? 2'h1 : 2'h0;
      MODE_FOUR_II: base = (line_kind == LINE_B) ? 2'h2 : 2'h0;
      default: base = 2'h0;
    endcase
  end
  // Position advances once per pixel and restarts on line resync
  assign pos_d = line_restart ? 2'h0 : (pix_en ? ((pos_q == wrap) ? 2'h0 : pos_q + 2'h1) : pos_q);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pos_q <= 2'h0;
    else
      pos_q <= pos_d;
  end
  // Mosaic modes add base; four-colour II rotates modulo 4; three-colour II counts down on LINE_B lines
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gain_sel <= 2'h0;
    else if (rev)
      gain_sel <= 2'h2 - pos_d;
    else
      gain_sel <= base + pos_d;
  end
endmodule
`default_nettype wire

// ---- sync_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  input wire logic core_clk,
  output logic horizontal_sync,
  output logic vertical_sync,
  output logic field_indicator,
  output logic pix_en
);
  initial
  begin
    horizontal_sync = 1'b1;
    vertical_sync = 1'b1;
    field_indicator = 1'b0;
    pix_en = 1'b0;
  end
  // Frame sync falls one clock ahead of the line sync; returns just after the edge that follows the resync edge
  task automatic line_start(input logic v);
    if (v)
    begin
      @(posedge core_clk) #1;
      vertical_sync = 1'b0;
    end
    @(posedge core_clk) #1;
    horizontal_sync = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    horizontal_sync = 1'b1;
    vertical_sync = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic pixel();
    @(posedge core_clk) #1;
    pix_en = 1'b1;
    @(posedge core_clk) #1;
    pix_en = 1'b0;
  endtask
  task automatic set_field(input logic f);
    @(posedge core_clk) #1;
    field_indicator = f;
  endtask
endmodule
`default_nettype wire

// ---- test_ccd_color_gain_steering.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ccd_color_gain_steering;
  import steer_pkg::*;
  logic core_clk, rst_b, pix_en, vertical_sync, horizontal_sync, field_indicator;
  logic pga_wr, vga_wr, clamp_wr, clamp_loop_en, clamp_active, black_clamp_pulse;
  logic internal_mode, ext_black_clamp_pulse;
  logic [1:0] cfg_sel, gain_sel;
  logic [5:0] pga_wdata, gain_value;
  logic [9:0] vga_wdata, vga_code;
  logic [7:0] clamp_wdata, clamp_level, operating_mode_reg;
  logic [11:0] h_count;
  steer_mode_t ctl_mode;
  int checked = 0;
  int mismatches = 0;
  logic [31:0] exp_a [7] = '{32'h01010101, 32'h01010101, 32'h01010101, 32'h01201201,
    32'h01201201, 32'h01230123, 32'h01230123};
  logic [31:0] exp_b [7] = '{32'h23232323, 32'h23232323, 32'h12121212, 32'h01201201,
    32'h21021021, 32'h01230123, 32'h23012301};
  sync_source src (.core_clk(core_clk), .horizontal_sync(horizontal_sync),
    .vertical_sync(vertical_sync), .field_indicator(field_indicator), .pix_en(pix_en));
  ccd_color_gain_steering dut (.*, .clamp_on_pos(12'h002),
    .clamp_off_pos(12'h016), .clamp_line_div(4'h0));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic s_regs();
    for (int c = 0; c < 4; c++)
    begin
      @(posedge core_clk) #1;
      cfg_sel = 2'(c);
      pga_wdata = {2'(c), 4'hA};
      pga_wr = 1'b1;
    end
    @(posedge core_clk) #1;
    pga_wr = 1'b0;
    vga_wr = 1'b1;
    clamp_wr = 1'b1;
    @(posedge core_clk) #1;
    vga_wr = 1'b0;
    clamp_wr = 1'b0;
    chk("vga_code", 12'h2A5, 12'(vga_code));
    chk("clamp_level", 12'h0C3, 12'(clamp_level));
    @(posedge core_clk) #1;
    vga_wdata = 10'h15A;
    clamp_wdata = 8'h3C;
    vga_wr = 1'b1;
    clamp_wr = 1'b1;
    @(posedge core_clk) #1;
    vga_wr = 1'b0;
    clamp_wr = 1'b0;
    chk("vga_code", 12'h15A, 12'(vga_code));
    chk("clamp_level", 12'h03C, 12'(clamp_level));
  endtask
  // First value at resync, then one per pixel; gain value lags selection by a cycle
  task automatic run_line(input logic v, input logic [31:0] e);
    src.line_start(v);
    chk("gain_sel", 12'(e[29:28]), 12'(gain_sel));
    chk("h_count", 12'h0, h_count);
    for (int i = 1; i < 8; i++)
    begin
      src.pixel();
      chk("gain_sel", 12'(e[28-4*i +: 2]), 12'(gain_sel));
      chk("gain_value", {6'h0, e[32-4*i +: 2], 4'hA}, 12'(gain_value));
    end
  endtask
  task automatic s_modes();
    for (int m = 0; m < 7; m++)
    begin
      src.set_field(1'b0);
      ctl_mode = steer_mode_t'(m);
      run_line(1'b1, exp_a[m]);
      src.set_field(1'b1);
      run_line(1'b0, exp_b[m]);
    end
  endtask
  task automatic s_clamp();
    @(posedge core_clk) #1;
    operating_mode_reg = 8'h04;
    #1;
    chk("clamp_loop_en", 12'h0, 12'(clamp_loop_en));
    run_line(1'b1, exp_a[6]);
    chk("clamp_level", 12'h03C, 12'(clamp_level));
    chk("black_clamp_pulse", 12'h1, 12'(black_clamp_pulse));
    chk("clamp_active", 12'h0, 12'(clamp_active));
    operating_mode_reg = 8'h00;
    #1;
    chk("clamp_loop_en", 12'h1, 12'(clamp_loop_en));
    @(posedge core_clk) #1;
    chk("clamp_active", 12'h1, 12'(clamp_active));
    internal_mode = 1'b0;
    @(posedge core_clk) #1;
    chk("black_clamp_pulse", 12'h0, 12'(black_clamp_pulse));
    ext_black_clamp_pulse = 1'b1;
    @(posedge core_clk) #1;
    chk("black_clamp_pulse", 12'h1, 12'(black_clamp_pulse));
    chk("clamp_active", 12'h1, 12'(clamp_active));
  endtask
  initial
  begin
    rst_b = 1'b0;
    {pga_wr, vga_wr, clamp_wr, cfg_sel, pga_wdata} = '0;
    vga_wdata = 10'h2A5;
    clamp_wdata = 8'hC3;
    internal_mode = 1'b1;
    ext_black_clamp_pulse = 1'b0;
    operating_mode_reg = 8'h00;
    ctl_mode = MODE_MOSAIC_SEP;
    repeat (20) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    s_regs();
    s_modes();
    s_clamp();
    results();
  end
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
